// ---- shared/lcd_pkg.sv ----
/*
 * lcd_pkg: constants and types of the LCD multiplex drive timing block.
 * Assumes a 20 MHz system clock and a display memory held outside the block.
 */
package lcd_pkg;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_HZ       = 20_000_000;
    localparam int OSC_HZ       = 1970;
    localparam int OSC_HALF_DIV = CLK_HZ / (2 * OSC_HZ);
    localparam int FRAME_DIV    = 24;
    localparam int DIV_W        = 16;

    // ****************************************************************
    // geometry
    // ****************************************************************
    localparam int NUM_SEG = 60;
    localparam int NUM_BP  = 4;

    // ****************************************************************
    // drive level codes, per pin two bits
    // ****************************************************************
    localparam logic [1:0] LVL_VSS  = 2'h0;
    localparam logic [1:0] LVL_LOW  = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;
    localparam logic [1:0] LVL_VLCD = 2'h3;
    localparam logic [1:0] LVL_MID  = LVL_LOW;

    // ****************************************************************
    // drive modes and reset values
    // ****************************************************************
    typedef enum logic [1:0] {
        MODE_STATIC = 2'h0,
        MODE_MUX2   = 2'h1,
        MODE_MUX3   = 2'h2,
        MODE_MUX4   = 2'h3
    } lcd_mode_type;

    localparam lcd_mode_type MODE_RST      = MODE_MUX4;
    localparam logic         BIAS_HALF_RST = 1'b0;
    localparam logic         DISP_EN_RST   = 1'b0;

    typedef struct packed {
        logic [1:0]           osc_s;
        logic [1:0]           clk_s;
        logic [1:0]           sync_s;
        logic                 clk_prev;
        logic                 sync_prev;
        logic [DIV_W-1:0]     div_cnt;
        logic                 osc_clk;
        logic                 clk_oe;
        lcd_mode_type         mode;
        logic                 bias_half;
        logic                 disp_en;
        logic [4:0]           tick_cnt;
        logic [1:0]           slot;
        logic                 pol;
        logic                 rd;
        logic [1:0]           row;
        logic                 load_pend;
        logic [NUM_SEG-1:0]   disp;
        logic                 sync_oe;
        logic [2*NUM_BP-1:0]  bp_lvl;
        logic [2*NUM_SEG-1:0] seg_lvl;
    } lcd_state_type;

endpackage

// ---- rtl/lcd_drive.sv ----
/*
 * lcd_drive: backplane and segment drive timing for a multiplexed segment LCD.
 * Assumes a command decoder on clk_in supplies mode and enable, and a display
 * memory answers a row read one cycle after ram_rd_out.
 */
// How it works
// - drive mode and bias are latched from the mode-set command.
// - static mode uses one backplane and only two levels.
// - 1:2 mode drives two backplanes at half or third bias.
// - 1:3 mode runs three slots per frame, third bias by default.
// - 1:4 mode runs four slots per frame, third bias by default.
// - half bias is also accepted in 1:3 and 1:4 modes.
// - one drive clock, internal oscillator or external pin, times everything.
// - select low runs the internal oscillator and drives it on the clock pin.
// - select high stops the oscillator and takes the clock pin as input.
// - a frame lasts 24 drive clocks whatever the clock source.
// - cascaded parts align frames via the shared active-low sync line.
// - each slot start reads the next display row from memory.
// - the display register holds that row for the whole slot.
// - all 60 segment levels come from phase and display register bit.
// - reset selects 1:4 third bias, clears pointers, display disabled.
// - unused backplanes copy the matching active backplane.
// - slot n uses display row n as segment data.
`timescale 1ns/1ps
module lcd_drive #(
    parameter int OSC_HALF = lcd_pkg::OSC_HALF_DIV
) (
    input  wire logic                          clk_in,              // system clock
    input  wire logic                          resetn_in,           // async reset
    input  wire logic                          osc_sel_in,          // pin, high = ext clk
    input  wire logic                          clk_pin_in,          // clock pin level
    output logic                               clk_pin_out,         // clock pin drive
    output logic                               clk_pin_oe_out,      // clock pin enable
    input  wire logic                          sync_n_in,           // sync line level
    output logic                               sync_n_out,          // sync drive value
    output logic                               sync_n_oe_out,       // sync pull-down
    input  wire logic                          mode_set_in,         // mode-set strobe
    input  wire lcd_pkg::lcd_mode_type         mode_in,             // requested mode
    input  wire logic                          bias_half_in,        // 1 = half bias
    input  wire logic                          display_en_in,       // display enable
    output logic                               ram_rd_out,          // row read strobe
    output logic [1:0]                         ram_row_out,         // row to read
    input  wire logic [lcd_pkg::NUM_SEG-1:0]   ram_data_in,         // row data
    output logic [2*lcd_pkg::NUM_BP-1:0]       backplane_outputs_out, // bp levels
    output logic [2*lcd_pkg::NUM_SEG-1:0]      segment_outputs_out    // seg levels
);
    import lcd_pkg::*;

    // ****************************************************************
    // decode helpers
    // ****************************************************************
    function automatic logic [2:0] bp_count(input lcd_mode_type m);
        unique case (m)
            MODE_STATIC: bp_count = 3'h1;
            MODE_MUX2:   bp_count = 3'h2;
            MODE_MUX3:   bp_count = 3'h3;
            MODE_MUX4:   bp_count = 3'h4;
        endcase
    endfunction

    function automatic logic [4:0] slot_len(input lcd_mode_type m);
        slot_len = 5'(FRAME_DIV / int'(bp_count(m)));
    endfunction

    function automatic logic [1:0] bp_src(input lcd_mode_type m, input logic [1:0] k);
        unique case (m)
            MODE_STATIC: bp_src = 2'h0;
            MODE_MUX2:   bp_src = {1'b0, k[0]};
            MODE_MUX3:   bp_src = (k == 2'h3) ? 2'h1 : k;
            MODE_MUX4:   bp_src = k;
        endcase
    endfunction

    lcd_state_type r;
    lcd_state_type nxt;
    logic          tick;
    logic          sync_fall;
    logic          frame_end;
    logic          half;
    logic [1:0]    ext;
    logic [1:0]    sel;
    logic [1:0]    off;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        nxt = r;
        tick = 1'b0;
        nxt.osc_s = {r.osc_s[0], osc_sel_in};
        nxt.clk_s = {r.clk_s[0], clk_pin_in};
        nxt.sync_s = {r.sync_s[0], sync_n_in};
        nxt.clk_prev = r.clk_s[1];
        nxt.sync_prev = r.sync_s[1];
        nxt.rd = 1'b0;
        nxt.load_pend = r.rd;
        nxt.clk_oe = ~r.osc_s[1];
        if (r.osc_s[1]) begin
            nxt.div_cnt = '0;
            nxt.osc_clk = 1'b0;
            tick = r.clk_s[1] & ~r.clk_prev;
        end else if (r.div_cnt == DIV_W'(OSC_HALF - 1)) begin
            nxt.div_cnt = '0;
            nxt.osc_clk = ~r.osc_clk;
            tick = ~r.osc_clk;
        end else begin
            nxt.div_cnt = r.div_cnt + 1'b1;
        end
        nxt.disp_en = display_en_in;
        frame_end = (r.slot == 2'(bp_count(r.mode) - 3'h1));
        sync_fall = r.sync_prev & ~r.sync_s[1] & ~r.sync_oe;
        if (mode_set_in) begin
            nxt.mode = mode_in;
            nxt.bias_half = bias_half_in;
            nxt.tick_cnt = '0;
            nxt.slot = '0;
            nxt.rd = 1'b1;
            nxt.row = '0;
        end else if (sync_fall) begin
            nxt.tick_cnt = '0;
            nxt.slot = '0;
            nxt.rd = 1'b1;
            nxt.row = '0;
        end else if (tick) begin
            nxt.sync_oe = 1'b0;
            if (r.tick_cnt == slot_len(r.mode) - 5'h1) begin
                nxt.tick_cnt = '0;
                nxt.slot = frame_end ? 2'h0 : r.slot + 2'h1;
                nxt.pol = frame_end ? ~r.pol : r.pol;
                nxt.sync_oe = frame_end;
                nxt.rd = 1'b1;
                nxt.row = nxt.slot;
            end else begin
                nxt.tick_cnt = r.tick_cnt + 5'h1;
            end
        end
        if (r.load_pend) begin
            nxt.disp = ram_data_in;
        end
        half = r.bias_half | (r.mode == MODE_STATIC);
        ext = r.pol ? LVL_VLCD : LVL_VSS;
        sel = r.pol ? LVL_VSS : LVL_VLCD;
        off = half ? ext : (r.pol ? LVL_HIGH : LVL_LOW);
        for (int k = 0; k < NUM_BP; k++) begin
            if (!r.disp_en) begin
                nxt.bp_lvl[2*k +: 2] = LVL_VLCD;
            end else if (bp_src(r.mode, 2'(k)) == r.slot) begin
                nxt.bp_lvl[2*k +: 2] = ext;
            end else begin
                nxt.bp_lvl[2*k +: 2] = half ? LVL_MID : (r.pol ? LVL_LOW : LVL_HIGH);
            end
        end
        for (int i = 0; i < NUM_SEG; i++) begin
            if (!r.disp_en) begin
                nxt.seg_lvl[2*i +: 2] = LVL_VLCD;
            end else begin
                nxt.seg_lvl[2*i +: 2] = r.disp[i] ? sel : off;
            end
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            r <= '0;
            r.osc_s <= 2'h3;
            r.clk_s <= 2'h3;
            r.sync_s <= 2'h3;
            r.clk_prev <= 1'b1;
            r.sync_prev <= 1'b1;
            r.mode <= MODE_RST;
            r.bias_half <= BIAS_HALF_RST;
            r.disp_en <= DISP_EN_RST;
            r.bp_lvl <= '1;
            r.seg_lvl <= '1;
        end else begin
            r <= nxt;
        end
    end

    assign clk_pin_out = r.osc_clk;
    assign clk_pin_oe_out = r.clk_oe;
    assign sync_n_out = 1'b0;
    assign sync_n_oe_out = r.sync_oe;
    assign ram_rd_out = r.rd;
    assign ram_row_out = r.row;
    assign backplane_outputs_out = r.bp_lvl;
    assign segment_outputs_out = r.seg_lvl;

    // ****************************************************************
    // checks
    // ****************************************************************
    disabled_out_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !r.disp_en |=> backplane_outputs_out == '1 && segment_outputs_out == '1)
        else $error("disabled display not at full level");
    static_levels_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        r.disp_en && r.mode == MODE_STATIC
        |=> backplane_outputs_out[1:0] == LVL_VSS || backplane_outputs_out[1:0] == LVL_VLCD)
        else $error("static mode used a middle level");
    mux2_copy_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        r.mode == MODE_MUX2 |=> backplane_outputs_out[3:0] == backplane_outputs_out[7:4])
        else $error("1:2 backplane pairs differ");
    mux3_copy_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        r.mode == MODE_MUX3 |=> backplane_outputs_out[7:6] == backplane_outputs_out[3:2])
        else $error("1:3 fourth backplane not copying second");
    slot_range_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        r.slot < 2'(bp_count(r.mode) - 3'h1) || r.slot == 2'(bp_count(r.mode) - 3'h1))
        else $error("slot beyond backplane count");
    frame_len_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        r.tick_cnt < slot_len(r.mode))
        else $error("slot counter beyond frame division");
    osc_pin_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        r.osc_s[1] ##1 r.osc_s[1] |=> !clk_pin_oe_out && !clk_pin_out)
        else $error("clock pin driven with external clock selected");
    row_load_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ram_rd_out |=> r.load_pend ##1 r.disp == $past(ram_data_in))
        else $error("display register missed the row");
    sync_frame_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        $rose(r.sync_oe) |-> r.slot == 2'h0 && r.tick_cnt == 5'h0 && ram_rd_out)
        else $error("sync not at frame start");
    seg_on_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        r.disp_en && r.disp[0] && r.pol |=> segment_outputs_out[1:0] == LVL_VSS)
        else $error("on segment not at opposite extreme");
    half_bias_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        r.disp_en && r.bias_half && !r.disp[0]
        |=> segment_outputs_out[1:0] == LVL_VSS || segment_outputs_out[1:0] == LVL_VLCD)
        else $error("half bias off segment at third level");

    // ****************************************************************
    // checks: sequencing, clock and sync
    // ****************************************************************
    mode_latch_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        mode_set_in |=> r.mode == $past(mode_in) && r.bias_half == $past(bias_half_in))
        else $error("mode-set not latched");
    mode_restart_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        mode_set_in
        |=> ram_rd_out && ram_row_out == 2'h0 && r.slot == 2'h0 && r.tick_cnt == 5'h0)
        else $error("mode-set did not restart the frame");
    row_slot_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ram_rd_out |-> ram_row_out == r.slot)
        else $error("row read does not match slot");
    disp_hold_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !r.load_pend |=> $stable(r.disp))
        else $error("display register changed inside a slot");
    tick_only_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !tick && !mode_set_in && !sync_fall
        |=> $stable(r.tick_cnt) && $stable(r.slot) && $stable(r.pol))
        else $error("frame state moved without a drive tick");
    pol_flip_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        tick && !mode_set_in && !sync_fall && frame_end
        && r.tick_cnt == slot_len(r.mode) - 5'h1
        |=> r.pol != $past(r.pol))
        else $error("polarity kept across a frame end");
    pol_frame_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        $changed(r.pol) |-> r.slot == 2'h0 && ram_rd_out && sync_n_oe_out)
        else $error("polarity changed away from frame start");
    clk_drive_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !r.osc_s[1] ##1 !r.osc_s[1] |=> clk_pin_oe_out)
        else $error("clock pin not driven with internal oscillator");
    osc_toggle_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !r.osc_s[1] && r.div_cnt == DIV_W'(OSC_HALF - 1) |=> clk_pin_out != $past(clk_pin_out))
        else $error("oscillator did not toggle at divider end");
    ext_div_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        r.osc_s[1] |=> r.div_cnt == DIV_W'(0))
        else $error("oscillator divider running with external clock");
    sync_restart_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        sync_fall && !mode_set_in
        |=> ram_rd_out && ram_row_out == 2'h0 && r.tick_cnt == 5'h0)
        else $error("sync edge did not restart the frame");
    sync_release_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        sync_n_oe_out && tick && !mode_set_in && !sync_fall |=> !sync_n_oe_out)
        else $error("sync pulled low beyond one drive tick");

    // ****************************************************************
    // checks: slot ranges and drive levels
    // ****************************************************************
    mux3_slots_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        r.mode == MODE_MUX3 |-> r.slot != 2'h3)
        else $error("1:3 mode reached a fourth slot");
    mux2_slots_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        r.mode == MODE_MUX2 |-> !r.slot[1])
        else $error("1:2 mode reached a third slot");
    static_slot_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        r.mode == MODE_STATIC |-> r.slot == 2'h0)
        else $error("static mode left slot zero");
    static_all_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        r.mode == MODE_STATIC |=> backplane_outputs_out == {4{backplane_outputs_out[1:0]}})
        else $error("static backplanes differ");
    bp0_select_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        r.disp_en && r.slot == 2'h0
        |=> backplane_outputs_out[1:0] == ($past(r.pol) ? LVL_VLCD : LVL_VSS))
        else $error("first backplane not selected in slot zero");
    bp3_mux4_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        r.disp_en && r.mode == MODE_MUX4 && r.slot == 2'h3
        |=> backplane_outputs_out[7:6] == ($past(r.pol) ? LVL_VLCD : LVL_VSS))
        else $error("fourth backplane not selected in last slot");
    mux4_unsel_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        r.disp_en && r.mode == MODE_MUX4 && !r.bias_half && r.slot == 2'h0
        |=> backplane_outputs_out[3:2] == ($past(r.pol) ? LVL_LOW : LVL_HIGH))
        else $error("unselected backplane not at third level");
    mux2_half_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        r.disp_en && r.mode == MODE_MUX2 && r.bias_half && r.slot == 2'h0
        |=> backplane_outputs_out[3:2] == LVL_MID)
        else $error("half bias unselected backplane not at middle");
    static_off_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        r.disp_en && r.mode == MODE_STATIC && !r.disp[1]
        |=> segment_outputs_out[3:2] == ($past(r.pol) ? LVL_VLCD : LVL_VSS))
        else $error("static off segment not with backplane");
    seg_third_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        r.disp_en && !r.bias_half && r.mode != MODE_STATIC && !r.disp[0]
        |=> segment_outputs_out[1:0] == ($past(r.pol) ? LVL_HIGH : LVL_LOW))
        else $error("third bias off segment at wrong level");
    seg_on_neg_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        r.disp_en && r.disp[59] && !r.pol |=> segment_outputs_out[119:118] == LVL_VLCD)
        else $error("on segment not at full level");

endmodule

// ---- dv/lcd_far_model.sv ----
/*
 * lcd_far_model: display memory, external clock source and cascade partner.
 * Assumes the bench supplies four 60-bit rows and a request to pull sync low.
 */
`timescale 1ns/1ps
module lcd_far_model (
    input  wire logic         clk_in,      // system clock
    input  wire logic [239:0] rows_in,     // rows 3..0, 60 bits each
    input  wire logic         rd_in,       // row read strobe
    input  wire logic [1:0]   row_in,      // row index
    output logic [59:0]       data_out,    // row data
    input  wire logic         osc_sel_in,  // high = external clock wanted
    input  wire logic         pin_drv_in,  // device clock drive value
    input  wire logic         pin_oe_in,   // device clock drive enable
    output logic              clk_pin_out, // resolved clock pin
    input  wire logic         sync_oe_in,  // device pulls sync low
    input  wire logic         pull_in,     // cascaded part pulls sync low
    output logic              sync_n_out   // resolved sync line
);
    logic        ext_r  = 1'b0;
    logic [1:0]  cnt_r  = 2'h0;
    logic        hold_r = 1'b0;
    logic [1:0]  held_r = 2'h0;
    logic [59:0] junk_r = '0;

    // ****************************************************************
    // memory answers during the strobe and one cycle after, else junk
    // ****************************************************************
    always @(posedge clk_in) begin
        hold_r <= rd_in;
        held_r <= rd_in ? row_in : held_r;
        junk_r <= ~data_out;
        cnt_r  <= cnt_r + 2'h1;
        if (cnt_r == 2'h3) begin
            ext_r <= ~ext_r;
        end
    end
    assign data_out = rd_in ? rows_in[row_in*60 +: 60] :
                      hold_r ? rows_in[held_r*60 +: 60] : junk_r;
    // undriven pin shows a changing pattern
    assign clk_pin_out = pin_oe_in ? pin_drv_in : (osc_sel_in ? ext_r : cnt_r[0]);
    assign sync_n_out  = ~(sync_oe_in | pull_in);
endmodule

// ---- dv/test_lcd_multiplex_drive_timing.sv ----
/*
 * test_lcd_multiplex_drive_timing: self-checking bench for lcd_drive.
 * Assumes lcd_pkg and lcd_far_model; an integer model tracks slot, row and polarity.
 */
`timescale 1ns/1ps
module test_lcd_multiplex_drive_timing;
    import lcd_pkg::*;
    localparam int HALF = 4;
    logic         clk_in    = 1'b0;
    logic         resetn_in = 1'b0;
    logic         osc_sel   = 1'b0;
    logic         mode_set  = 1'b0;
    lcd_mode_type mode      = MODE_MUX4;
    logic         bias_half = 1'b0;
    logic         disp_en   = 1'b0;
    logic         pull_sync = 1'b0;
    logic [255:0] rows      = '0;
    logic         clk_pin, clk_drv, clk_oe, sync_n, sync_val, sync_oe, ram_rd;
    logic [1:0]   ram_row;
    logic [59:0]  ram_data;
    logic [7:0]   bp, ebp;
    logic [119:0] seg, eseg;
    int           miscompares = 0;
    int           checked = 0;
    int           seed = 32'h14f7;
    int           cyc = 0;
    int           nreads, last_rd, slot, mm, n, k, j, t;
    int           chk_at = -1;
    bit           fresh, mh, pol, active, gap_ok;

    always #25 clk_in = ~clk_in;
    always @(posedge clk_in) cyc <= cyc + 1;

    lcd_drive #(.OSC_HALF(HALF)) DUT (.clk_in(clk_in), .resetn_in(resetn_in),
        .osc_sel_in(osc_sel), .clk_pin_in(clk_pin), .clk_pin_out(clk_drv),
        .clk_pin_oe_out(clk_oe), .sync_n_in(sync_n), .sync_n_out(sync_val),
        .sync_n_oe_out(sync_oe), .mode_set_in(mode_set), .mode_in(mode),
        .bias_half_in(bias_half), .display_en_in(disp_en), .ram_rd_out(ram_rd),
        .ram_row_out(ram_row), .ram_data_in(ram_data), .backplane_outputs_out(bp),
        .segment_outputs_out(seg));
    lcd_far_model far (.clk_in(clk_in), .rows_in(rows[239:0]), .rd_in(ram_rd),
        .row_in(ram_row), .data_out(ram_data), .osc_sel_in(osc_sel), .pin_drv_in(clk_drv),
        .pin_oe_in(clk_oe), .clk_pin_out(clk_pin), .sync_oe_in(sync_oe),
        .pull_in(pull_sync), .sync_n_out(sync_n));

    // ****************************************************************
    // checking and closing
    // ****************************************************************
    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: value %0h, wanted %0h", $time, got, exp);
        end
    endtask
    task automatic cmp_lvl(input logic [127:0] got, input logic [127:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: levels %0h, wanted %0h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // model: follows every row read, then checks levels six cycles after it
    // ****************************************************************
    always @(negedge clk_in) begin
        if (active && ram_rd === 1'b1) begin
            n = (mm == 0) ? 1 : mm + 1;
            if (fresh) begin
                slot = 0;
                gap_ok = 0;
            end else begin
                slot = (slot + 1) % n;
                // first slot after a restart starts off the tick phase, so skip its length
                if (gap_ok) begin
                    cmp_val(cyc - last_rd, 24 / n * 2 * HALF);
                end
                gap_ok = 1;
                if (slot == 0) begin
                    pol = !pol;
                    cmp_val(sync_oe, 1);
                end
            end
            cmp_val(ram_row, slot);
            fresh = 0;
            last_rd = cyc;
            chk_at = cyc + 6;
            nreads++;
        end
        if (active && cyc == chk_at) begin
            for (k = 0; k < 4; k++) begin
                j = (mm == 0) ? 0 : (mm == 1) ? k % 2 : (mm == 2 && k == 3) ? 1 : k;
                ebp[2*k +: 2] = (j == slot) ? (pol ? LVL_VLCD : LVL_VSS) :
                                mh ? LVL_MID : (pol ? LVL_LOW : LVL_HIGH);
            end
            for (k = 0; k < 60; k++) begin
                eseg[2*k +: 2] = rows[slot*60+k] ? (pol ? LVL_VSS : LVL_VLCD) :
                    (mh || mm == 0) ? (pol ? LVL_VLCD : LVL_VSS) : (pol ? LVL_HIGH : LVL_LOW);
            end
            cmp_lvl(bp, ebp);
            cmp_lvl(seg, eseg);
        end
    end

    task automatic run(input lcd_mode_type m, input bit h);
        int i;
        @(posedge clk_in);
        mode <= m;
        bias_half <= h;
        mode_set <= 1'b1;
        for (i = 0; i < 8; i++) rows[32*i +: 32] <= $random(seed);
        @(posedge clk_in);
        mode_set <= 1'b0;
        mm = int'(m);
        mh = h;
        fresh = 1;
        chk_at = -1;
        nreads = 0;
        active = 1;
        n = (mm == 0) ? 1 : mm + 1;
        for (i = 0; i < 1000 && nreads < 2 * n + 2; i++) @(negedge clk_in);
        cmp_val(nreads >= 2 * n + 2, 1);
    endtask

    initial begin
        @(negedge clk_in);
        cmp_lvl({bp, seg}, {128{1'b1}});
        cmp_val({clk_oe, sync_oe, ram_rd, ram_row}, 0);
        repeat (3) @(posedge clk_in);
        resetn_in <= 1'b1;
        repeat (6) @(negedge clk_in);
        cmp_lvl({bp, seg}, {128{1'b1}});
        cmp_val(clk_oe, 1);
        @(posedge clk_in);
        disp_en <= 1'b1;
        for (t = 0; t < 8; t++) run(lcd_mode_type'(3 - t / 2), t[0]);
        @(posedge clk_in);
        osc_sel <= 1'b1;
        run(MODE_MUX4, 1'b0);
        cmp_val(clk_oe, 0);
        active = 0;
        for (t = 0; t < 200 && !(ram_rd === 1'b1 && ram_row === 2'h1); t++) @(negedge clk_in);
        @(posedge clk_in);
        pull_sync <= 1'b1;
        @(negedge clk_in);
        for (t = 0; t < 12 && ram_rd !== 1'b1; t++) @(negedge clk_in);
        cmp_val({ram_rd, ram_row}, 3'h4);
        cmp_val(sync_val, 0);
        @(posedge clk_in);
        pull_sync <= 1'b0;
        wrap_up();
    end

    initial begin
        #(30000 * 50);
        miscompares++;
        $display("unexpected at %0t: watchdog expired", $time);
        wrap_up();
    end
endmodule
